// ==== design/gpio_sampler.sv ====
// Five-pin port unit: per-pin PWM/level output, drive mode, function
// select, 32 Hz bounce-free sampling with edge tracking.
// Assumes pins arrive asynchronously and the register master never waits.
//
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/1ps

// Notes on behaviour
// - Pin index above four is ignored
// - Short command sets value, long adds config
// - 0 low, 100 high, between is duty
// - Intermediate levels are 100 Hz PWM
// - Config byte: mode low three, function bit three
// - Modes 000, 001, 011 drive as listed
// - Modes 100, 101, 111 drive as listed
// - Mode 010 input, 110 reserved
// - Function bit picks shared or user level
// - All pins sampled at 32 Hz always
// - Edges tracked per pin, cleared on query
// - Sampling at slow rate rejects bounce
// - Pull-up with switch reads 1 open
// - Pins 0 to 4 carry shared functions
// - Configuration saved on store write; reset loads factory defaults
// - Status: state bit0, fall bit1, rise bit2
module gpio_sampler
	import gpio_sampler_pkg::*;
(
	input wire logic I_CLK,
	input wire logic I_RST_N,
	input wire logic I_CE,
	input wire logic [3:0] I_ADDR,
	input wire logic [31:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	input wire logic [NUM_PINS-1:0] I_PIN,
	output logic [31:0] O_RDATA,
	output logic [NUM_PINS-1:0] O_PIN,
	output logic [NUM_PINS-1:0] O_PIN_OE,
	output logic [NUM_PINS-1:0] O_PULL_UP,
	output logic [NUM_PINS-1:0] O_PULL_DN,
	output logic [NUM_PINS-1:0] O_SLOW,
	output logic O_IRQ
);

	// Decide whether a drive mode may be written
	function automatic logic mode_ok(input logic [2:0] m);
		mode_ok = (m != DRV_RESERVED);
	endfunction : mode_ok

	// Translate a mode and a wanted level into pin controls
	function automatic pin_drive_type drive_of(input logic [2:0] m,
		input logic lvl);
		pin_drive_type d;
		d = '0;
		d.out = lvl;
		case (m)
			DRV_UP_PD:
			begin
				d.oe = lvl;
				d.pull_dn = ~lvl;
			end
			DRV_STRONG_FAST:
				d.oe = 1'b1;
			DRV_PU_DN:
			begin
				d.oe = ~lvl;
				d.pull_up = lvl;
			end
			DRV_SLOW_UP_HIZ:
			begin
				d.oe = lvl;
				d.slow = 1'b1;
			end
			DRV_STRONG_SLOW:
			begin
				d.oe = 1'b1;
				d.slow = 1'b1;
			end
			DRV_HIZ_SLOW_DN:
			begin
				d.oe = ~lvl;
				d.slow = 1'b1;
			end
			default:
				d.oe = 1'b0;
		endcase
		drive_of = d;
	endfunction : drive_of

	//--------------------------------------------------
	// Configuration registers
	//--------------------------------------------------
	logic [7:0] value_r [NUM_PINS];
	pin_config_byte_type cfg_r [NUM_PINS];
	logic [7:0] saved_value_r [NUM_PINS];
	pin_config_byte_type saved_cfg_r [NUM_PINS];
	logic [NUM_PINS-1:0] alt_out_r;
	logic [7:0] cmd_idx;
	logic [7:0] cmd_val;
	pin_config_byte_type cmd_cfg;
	logic cmd_long;
	logic cmd_ok;
	logic cmd_wr;
	logic store_wr;

	assign cmd_idx = I_WDATA[CMD_IDX_LSB +: 8];
	assign cmd_val = I_WDATA[CMD_VAL_LSB +: 8];
	assign cmd_cfg = pin_config_byte_type'(I_WDATA[CMD_CFG_LSB +: 4]);
	assign cmd_long = I_WDATA[CMD_LEN3_BIT];
	assign cmd_wr = I_WR && (I_ADDR == ADDR_CMD);
	assign store_wr = I_WR && (I_ADDR == ADDR_STORE);
	// upper config bits must be zero
	assign cmd_ok = (cmd_idx < 8'(NUM_PINS)) && (cmd_val <= VAL_MAX)
		&& (!cmd_long || (mode_ok(cmd_cfg.drive)
		&& I_WDATA[CMD_CFG_LSB+4 +: 4] == 4'h0));

	localparam logic [3:0] RST_CFG [NUM_PINS] =
		'{RST_CFG0, RST_CFG1, RST_CFG2, RST_CFG3, RST_CFG4};

	genvar g;
	generate
		for (g = 0; g < NUM_PINS; g++)
		begin : g_cfg
			always_ff @(posedge I_CLK or negedge I_RST_N)
			begin
				if (!I_RST_N)
				begin
					value_r[g] <= RST_VALUE;
					cfg_r[g] <= pin_config_byte_type'(RST_CFG[g]);
				end
				else if (I_CE && cmd_wr && cmd_ok && cmd_idx == 8'(g))
				begin
					value_r[g] <= cmd_val;
					if (cmd_long)
						cfg_r[g] <= cmd_cfg;
				end
			end

			always_ff @(posedge I_CLK or negedge I_RST_N)
			begin
				if (!I_RST_N)
				begin
					saved_value_r[g] <= RST_VALUE;
					saved_cfg_r[g] <= pin_config_byte_type'(RST_CFG[g]);
				end
				else if (I_CE && store_wr)
				begin
					saved_value_r[g] <= value_r[g];
					saved_cfg_r[g] <= cfg_r[g];
				end
			end
		end
	endgenerate

	always_ff @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
			alt_out_r <= '0;
		else if (I_CE && I_WR && I_ADDR == ADDR_ALT_OUT)
			alt_out_r <= I_WDATA[NUM_PINS-1:0];
	end

	//--------------------------------------------------
	// PWM timebase
	//--------------------------------------------------
	logic [19:0] step_cnt_r;
	logic [6:0] pwm_pos_r;

	always_ff @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			step_cnt_r <= '0;
			pwm_pos_r <= '0;
		end
		else if (I_CE)
		begin
			if (step_cnt_r == 20'(PWM_STEP_CYC - 1))
			begin
				step_cnt_r <= '0;
				if (pwm_pos_r == 7'(PWM_STEPS - 1))
					pwm_pos_r <= '0;
				else
					pwm_pos_r <= pwm_pos_r + 7'h01;
			end
			else
				step_cnt_r <= step_cnt_r + 20'h00001;
		end
	end

	//--------------------------------------------------
	// Pin drivers
	//--------------------------------------------------
	generate
		for (g = 0; g < NUM_PINS; g++)
		begin : g_drv
			logic lvl;
			pin_drive_type d;
			assign lvl = cfg_r[g].func_user
				? ({1'b0, pwm_pos_r} < value_r[g]) : alt_out_r[g];
			assign d = drive_of(cfg_r[g].drive, lvl);
			always_ff @(posedge I_CLK or negedge I_RST_N)
			begin
				if (!I_RST_N)
				begin
					O_PIN[g] <= 1'b0;
					O_PIN_OE[g] <= 1'b0;
					O_PULL_UP[g] <= 1'b0;
					O_PULL_DN[g] <= 1'b0;
					O_SLOW[g] <= 1'b0;
				end
				else if (I_CE)
				begin
					O_PIN[g] <= d.out;
					O_PIN_OE[g] <= d.oe;
					O_PULL_UP[g] <= d.pull_up;
					O_PULL_DN[g] <= d.pull_dn;
					O_SLOW[g] <= d.slow;
				end
			end
		end
	endgenerate

	//--------------------------------------------------
	// Input sampling
	//--------------------------------------------------
	logic [NUM_PINS-1:0] sync1_r, sync2_r, sync3_r;
	logic [NUM_PINS-1:0] stable_r, sample_r, rise_r, fall_r;
	logic [22:0] samp_cnt_r;
	logic samp_tick;
	logic query_wr;
	logic [NUM_PINS-1:0] query_sel;

	always_ff @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			sync1_r <= '0;
			sync2_r <= '0;
			sync3_r <= '0;
			stable_r <= '0;
		end
		else if (I_CE)
		begin
			sync1_r <= I_PIN;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
			stable_r <= (sync2_r ~^ sync3_r) & sync2_r
				| ~(sync2_r ~^ sync3_r) & stable_r;
		end
	end

	always_ff @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
			samp_cnt_r <= '0;
		else if (I_CE)
			samp_cnt_r <= samp_tick ? '0 : samp_cnt_r + 23'h000001;
	end
	assign samp_tick = (samp_cnt_r == 23'(SAMPLE_CYC - 1));

	assign query_wr = I_WR && (I_ADDR == ADDR_QUERY);
	generate
		for (g = 0; g < NUM_PINS; g++)
		begin : g_qsel
			assign query_sel[g] = query_wr
				&& I_WDATA[7:0] == 8'(g);
		end
	endgenerate

	always_ff @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
			sample_r <= '0;
		else if (I_CE && samp_tick)
			sample_r <= stable_r;
	end

	// sticky edges, set wins over query clear
	always_ff @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			rise_r <= '0;
			fall_r <= '0;
		end
		else if (I_CE)
		begin
			rise_r <= (rise_r & ~query_sel)
				| ({NUM_PINS{samp_tick}} & stable_r & ~sample_r);
			fall_r <= (fall_r & ~query_sel)
				| ({NUM_PINS{samp_tick}} & ~stable_r & sample_r);
		end
	end

	//--------------------------------------------------
	// Query latch and interrupts
	//--------------------------------------------------
	logic [7:0] status_r, qval_r;
	logic [3:0] qcfg_r;
	logic [NUM_PINS-1:0] int_stat_r, int_en_r;
	logic [2:0] q;

	assign q = I_WDATA[2:0];
	always_ff @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			status_r <= '0;
			qval_r <= '0;
			qcfg_r <= '0;
		end
		else if (I_CE && query_wr && I_WDATA[7:0] < 8'(NUM_PINS))
		begin
			status_r <= {5'h00, rise_r[q], fall_r[q], sample_r[q]};
			qval_r <= value_r[q];
			qcfg_r <= cfg_r[q];
		end
	end

	always_ff @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
			int_en_r <= '0;
		else if (I_CE && I_WR && I_ADDR == ADDR_INT_EN)
			int_en_r <= I_WDATA[NUM_PINS-1:0];
	end

	// Any sampled edge sets a sticky bit; set beats clear
	always_ff @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
			int_stat_r <= '0;
		else if (I_CE)
			int_stat_r <= (int_stat_r & ~((I_WR && I_ADDR == ADDR_INT_CLR)
				? I_WDATA[NUM_PINS-1:0] : '0))
				| ({NUM_PINS{samp_tick}} & (stable_r ^ sample_r));
	end

	always_ff @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
			O_IRQ <= 1'b0;
		else if (I_CE)
			O_IRQ <= |(int_stat_r & int_en_r);
	end

	//--------------------------------------------------
	// Read port
	//--------------------------------------------------
	always_ff @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
			O_RDATA <= '0;
		else if (I_CE)
		begin
			O_RDATA <= '0;
			if (I_RD)
				case (I_ADDR)
					ADDR_STATUS: O_RDATA <= {24'h0, status_r};
					ADDR_VALUE: O_RDATA <= {24'h0, qval_r};
					ADDR_CONFIG: O_RDATA <= {28'h0, qcfg_r};
					ADDR_INT_STAT: O_RDATA <= 32'(int_stat_r);
					ADDR_INT_EN: O_RDATA <= 32'(int_en_r);
					ADDR_ALT_OUT: O_RDATA <= 32'(alt_out_r);
					default: O_RDATA <= '0;
				endcase
		end
	end

endmodule : gpio_sampler

// ==== design/gpio_sampler_pkg.sv ====
// Package for the five-pin port unit: register map, fields, timing.
// Assumes a 100 MHz clock and a plain address/strobe register port.
package gpio_sampler_pkg;

	localparam int NUM_PINS = 5;
	localparam int CLK_HZ = 100_000_000;

	// PWM: 100 Hz period cut into 100 steps
	localparam int PWM_HZ = 100;
	localparam int PWM_STEPS = 100;
	localparam int PWM_STEP_CYC = CLK_HZ / (PWM_HZ * PWM_STEPS);
	// Input polling rate
	localparam int SAMPLE_HZ = 32;
	localparam int SAMPLE_CYC = CLK_HZ / SAMPLE_HZ;

	localparam logic [7:0] VAL_HIGH = 8'h64;
	localparam logic [7:0] VAL_MAX = 8'h64;

	// Register offsets
	localparam logic [3:0] ADDR_CMD = 4'h0;
	localparam logic [3:0] ADDR_QUERY = 4'h1;
	localparam logic [3:0] ADDR_STATUS = 4'h2;
	localparam logic [3:0] ADDR_VALUE = 4'h3;
	localparam logic [3:0] ADDR_CONFIG = 4'h4;
	localparam logic [3:0] ADDR_INT_STAT = 4'h5;
	localparam logic [3:0] ADDR_INT_EN = 4'h6;
	localparam logic [3:0] ADDR_INT_CLR = 4'h7;
	localparam logic [3:0] ADDR_STORE = 4'h8;
	localparam logic [3:0] ADDR_ALT_OUT = 4'h9;

	// Command word fields
	localparam int CMD_IDX_LSB = 0;
	localparam int CMD_VAL_LSB = 8;
	localparam int CMD_CFG_LSB = 16;
	localparam int CMD_LEN3_BIT = 24;

	// Status byte fields
	localparam int ST_STATE = 0;
	localparam int ST_FALL = 1;
	localparam int ST_RISE = 2;

	// Reset values: factory default configuration per pin
	localparam logic [7:0] RST_VALUE = 8'h00;
	localparam logic [3:0] RST_CFG0 = 4'h2;
	localparam logic [3:0] RST_CFG1 = 4'h3;
	localparam logic [3:0] RST_CFG2 = 4'h2;
	localparam logic [3:0] RST_CFG3 = 4'h2;
	localparam logic [3:0] RST_CFG4 = 4'h2;

	typedef enum logic [2:0] {
		DRV_UP_PD = 3'b000,
		DRV_STRONG_FAST = 3'b001,
		DRV_HIZ = 3'b010,
		DRV_PU_DN = 3'b011,
		DRV_SLOW_UP_HIZ = 3'b100,
		DRV_STRONG_SLOW = 3'b101,
		DRV_RESERVED = 3'b110,
		DRV_HIZ_SLOW_DN = 3'b111
	} drive_mode_field_type;

	typedef struct packed {
		logic func_user;
		drive_mode_field_type drive;
	} pin_config_byte_type;

	typedef struct packed {
		logic out;
		logic oe;
		logic pull_up;
		logic pull_dn;
		logic slow;
	} pin_drive_type;

endpackage : gpio_sampler_pkg

// ==== bench/gpio_sampler_sva.sv ====
// Checker for the five-pin port unit, bound to its top module.
// Assumes the port list of gpio_sampler and one clock domain.
`timescale 1ns/1ps
module gpio_sampler_chk
	import gpio_sampler_pkg::*;
(
	input wire logic I_CLK,
	input wire logic I_RST_N,
	input wire logic I_CE,
	input wire logic [3:0] I_ADDR,
	input wire logic [31:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	input wire logic [NUM_PINS-1:0] I_PIN,
	input wire logic [31:0] O_RDATA,
	input wire logic [NUM_PINS-1:0] O_PIN,
	input wire logic [NUM_PINS-1:0] O_PIN_OE,
	input wire logic [NUM_PINS-1:0] O_PULL_UP,
	input wire logic [NUM_PINS-1:0] O_PULL_DN,
	input wire logic [NUM_PINS-1:0] O_SLOW,
	input wire logic O_IRQ
);
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RST_N);
	// --------------------------------------------------------------
	// Read port, drive outputs and interrupt
	// --------------------------------------------------------------
	rd_idle_a: assert property (
		I_CE && !I_RD |=> O_RDATA == 32'h0)
		else $error("read data not idle");
	unmapped_rd_a: assert property (
		I_CE && I_RD && I_ADDR > ADDR_ALT_OUT |=> O_RDATA == 32'h0)
		else $error("unmapped read not zero");
	status_resv_a: assert property (
		I_RD && I_ADDR == ADDR_STATUS |=> O_RDATA[31:3] == 29'h0)
		else $error("status reserved bits set");
	cfg_range_a: assert property (
		I_RD && I_ADDR == ADDR_CONFIG |=> O_RDATA[31:4] == 28'h0)
		else $error("config above 15");
	value_range_a: assert property (
		I_RD && I_ADDR == ADDR_VALUE |=> O_RDATA <= 32'h64)
		else $error("value above 100");
	pull_drive_a: assert property (
		((O_PULL_UP | O_PULL_DN) & O_PIN_OE) == 5'h0)
		else $error("pull while driving");
	pull_level_a: assert property (
		((O_PULL_UP & ~O_PIN) | (O_PULL_DN & O_PIN)) == 5'h0)
		else $error("pull against level");
	slow_pull_a: assert property (
		(O_SLOW & (O_PULL_UP | O_PULL_DN)) == 5'h0)
		else $error("slow mode with pull");
	irq_mask_a: assert property (
		I_CE && I_WR && I_ADDR == ADDR_INT_EN && I_WDATA[4:0] == 5'h0
		##1 I_CE |=> !O_IRQ) else $error("masked interrupt high");
	rst_cfg_a: assert property (
		$rose(I_RST_N) |-> ##3 O_PIN_OE == 5'h02)
		else $error("boot drive wrong");
endmodule : gpio_sampler_chk

bind gpio_sampler gpio_sampler_chk gpio_sampler_chk_i (.I_CLK, .I_RST_N,
	.I_CE, .I_ADDR, .I_WDATA, .I_WR, .I_RD, .I_PIN, .O_RDATA, .O_PIN,
	.O_PIN_OE, .O_PULL_UP, .O_PULL_DN, .O_SLOW, .O_IRQ);

// ==== bench/gpio_pin_load.sv ====
// External load on the five pins: switches to ground, floating lines.
// Assumes the drive outputs of gpio_sampler.
`timescale 1ns/1ps
module gpio_pin_load
	import gpio_sampler_pkg::*;
(
	input wire logic i_clk,
	input wire logic [NUM_PINS-1:0] i_out,
	input wire logic [NUM_PINS-1:0] i_oe,
	input wire logic [NUM_PINS-1:0] i_pull_up,
	input wire logic [NUM_PINS-1:0] i_pull_dn,
	input wire logic [NUM_PINS-1:0] i_sw_closed,
	output logic [NUM_PINS-1:0] o_level
);
	logic [NUM_PINS-1:0] float_r = 5'h0;
	// Undriven lines wander every cycle
	always @(posedge i_clk) float_r <= ~float_r;
	always_comb
	begin
		for (int k = 0; k < NUM_PINS; k++)
		begin
			if (i_oe[k]) o_level[k] = i_out[k];
			else if (i_sw_closed[k]) o_level[k] = 1'b0;
			else if (i_pull_up[k]) o_level[k] = 1'b1;
			else if (i_pull_dn[k]) o_level[k] = 1'b0;
			else o_level[k] = float_r[k];
		end
	end
endmodule : gpio_pin_load

// ==== bench/test_gpio_sampler.sv ====
// Testbench for the five-pin port unit over its register port.
// Assumes gpio_sampler, its checker and the pin load model.
`timescale 1ns/1ps
module test_gpio_sampler
	import gpio_sampler_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic wr_stb = 1'b0;
	logic rd_stb = 1'b0;
	logic [4:0] sw = 5'h0;
	logic [4:0] lvl, pin, oe, pu, pd, slow;
	logic [31:0] rdata;
	logic irq;
	int error_cnt = 0;
	int n_tests = 0;
	logic ce = 1'b1;
	int cyc = 0;
	int t0;
	int t1;
	always #5 clk = ~clk;
	// Free cycle count for step length checks
	always @(posedge clk) cyc <= cyc + 1;
	gpio_sampler gpio_sampler_i (.I_CLK(clk), .I_RST_N(rst_n), .I_CE(ce),
		.I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr_stb), .I_RD(rd_stb),
		.I_PIN(lvl), .O_RDATA(rdata), .O_PIN(pin), .O_PIN_OE(oe),
		.O_PULL_UP(pu), .O_PULL_DN(pd), .O_SLOW(slow), .O_IRQ(irq));
	gpio_pin_load gpio_pin_load_i (.i_clk(clk), .i_out(pin), .i_oe(oe),
		.i_pull_up(pu), .i_pull_dn(pd), .i_sw_closed(sw), .o_level(lvl));
	// --------------------------------------------------------------
	// Access tasks
	// --------------------------------------------------------------
	task automatic close_out;
		if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : close_out
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge clk);
		wr_stb <= 1'b0;
	endtask : reg_wr
	task automatic reg_rd(input logic [3:0] a, input logic [31:0] exp);
		@(posedge clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clk);
		rd_stb <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask : reg_rd
	task automatic cmd(input logic [7:0] idx, input logic [7:0] val,
		input logic [3:0] cfg, input logic lng);
		reg_wr(ADDR_CMD, {7'h0, lng, 4'h0, cfg, val, idx});
	endtask : cmd
	// Bounded wait for pin 0 to fall; returns the cycle count
	task automatic wait_low(input int lim, output int t);
		int i;
		i = 0;
		while (pin[0] === 1'b1 && i < lim)
		begin
			@(posedge clk);
			#1;
			i++;
		end
		t = cyc;
		if (pin[0] !== 1'b0)
		begin
			error_cnt++;
			$display("MISMATCH %0t pin 0 never fell", $time);
			close_out();
		end
	endtask : wait_low
	// Pin 0 drive seen against the mode table
	task automatic drv(input logic [2:0] m, input logic l);
		logic e_oe;
		repeat (4) @(posedge clk);
		#1;
		case (m)
			3'b001, 3'b101: e_oe = 1'b1;
			3'b000, 3'b100: e_oe = l;
			3'b011, 3'b111: e_oe = !l;
			default: e_oe = 1'b0;
		endcase
		chk({oe[0], pu[0], pd[0], slow[0] & oe[0], pin[0] & oe[0]},
			{e_oe, m == 3'b011 && l, m == 3'b000 && !l, m[2] & e_oe,
			l & e_oe});
	endtask : drv
	// --------------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------------
	initial
	begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		reg_wr(ADDR_QUERY, 32'h1);
		reg_rd(ADDR_STATUS, 32'h0);
		reg_rd(ADDR_CONFIG, 32'h3);
		reg_rd(ADDR_VALUE, 32'h0);
		for (int m = 0; m < 8; m++)
		begin
			for (int l = 0; l < 2; l++)
			begin
				if (m != 6)
				begin
					cmd(8'h0, l[0] ? 8'h64 : 8'h0, {1'b1, m[2:0]}, 1'b1);
					drv(m[2:0], l[0]);
				end
			end
		end
		cmd(8'h0, 8'h0, 4'he, 1'b1);
		cmd(8'h5, 8'h0, 4'h9, 1'b1);
		cmd(8'h0, 8'h65, 4'h9, 1'b1);
		reg_wr(ADDR_CMD, 32'h0119_0000);
		reg_wr(ADDR_QUERY, 32'h0);
		reg_rd(ADDR_CONFIG, 32'hf);
		reg_rd(ADDR_VALUE, 32'h64);
		drv(3'b111, 1'b1);
		cmd(8'h0, 8'h0, 4'h1, 1'b0);
		reg_wr(ADDR_QUERY, 32'h0);
		reg_rd(ADDR_CONFIG, 32'hf);
		reg_rd(ADDR_VALUE, 32'h0);
		drv(3'b111, 1'b0);
		cmd(8'h0, 8'h0, 4'h1, 1'b1);
		reg_wr(ADDR_ALT_OUT, 32'h1);
		reg_rd(ADDR_ALT_OUT, 32'h1);
		drv(3'b001, 1'b1);
		// Clock enable low: the write must be lost
		@(posedge clk);
		ce <= 1'b0;
		reg_wr(ADDR_ALT_OUT, 32'h0);
		ce <= 1'b1;
		reg_rd(ADDR_ALT_OUT, 32'h1);
		drv(3'b001, 1'b1);
		reg_wr(ADDR_INT_EN, 32'h1f);
		reg_rd(ADDR_INT_EN, 32'h1f);
		reg_wr(ADDR_INT_CLR, 32'h1f);
		reg_rd(ADDR_INT_STAT, 32'h0);
		chk({31'h0, irq}, 32'h0);
		reg_wr(ADDR_INT_EN, 32'h0);
		// Step length between the falls of 1 and 2 percent duty
		cmd(8'h0, 8'h01, 4'h9, 1'b1);
		drv(3'b001, 1'b1);
		wait_low(PWM_STEP_CYC + 10, t0);
		cmd(8'h0, 8'h02, 4'h9, 1'b1);
		drv(3'b001, 1'b1);
		wait_low(PWM_STEP_CYC + 10, t1);
		chk(t1 - t0, PWM_STEP_CYC);
		reg_rd(4'hf, 32'h0);
		close_out();
	end
endmodule : test_gpio_sampler
